// *** rtl/omc_output_macrocell.sv ***
// eight output macrocells with global mode, polarity and io configuration
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "omc_defs.svh"

module omc_output_macrocell
    import omc_pkg::*;
#(
    parameter int NUM_CELLS = 8,
    parameter int PTERMS    = 8
) (
    // clock, reset, enable
    input  wire logic                        i_mclk,
    input  wire logic                        i_reset_n,
    input  wire logic                        i_ce,
    // register port
    input  wire logic [7:0]                  i_addr,
    input  wire logic [31:0]                 i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [31:0]                 o_rdata,
    // product terms from the and array, cell-major
    input  wire logic [NUM_CELLS*PTERMS-1:0] i_pterm,
    // feedback columns into the and array
    output logic      [NUM_CELLS-1:0]        o_array_fb,
    // dedicated pins: register clock / enable, or data inputs
    input  wire logic                        i_pin_clk,
    input  wire logic                        i_pin_oe_n,
    // macrocell pins, split into in, out and enable
    input  wire logic [NUM_CELLS-1:0]        i_cell_pin,
    output logic      [NUM_CELLS-1:0]        o_cell_out,
    output logic      [NUM_CELLS-1:0]        o_cell_oe,
    // current global mode
    output omc_mode_t                        o_mode
);

    // the pin routing below is drawn for exactly eight cells of eight terms
    if (NUM_CELLS != 8 || PTERMS != 8) begin : g_bad_size
        $error("omc_output_macrocell supports only 8 cells of 8 terms");
    end

    // inner pair: forced outputs in simple mode, where their pins are never fed back
    localparam int INNER_LO = NUM_CELLS / 2 - 1; // inner pair, low cell
    localparam int INNER_HI = NUM_CELLS / 2;     // inner pair, high cell

    // reset synchroniser: asserts at once, releases after two edges
    // every other process resets from this released copy
    logic rst_s1_r;
    logic rst_n;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // pins come from the board, unrelated to i_mclk
    // pin synchronisers, two flops each; only stage two is read
    logic [NUM_CELLS-1:0] pin_s1_r;   // first stage, cell pins
    logic [NUM_CELLS-1:0] pin_s2_r;   // settled cell pins
    logic                 clk_s1_r;   // first stage, clock pin
    logic                 clk_s2_r;   // settled clock pin
    logic                 clk_prev_r; // clock pin one cycle back
    logic                 oen_s1_r;   // first stage, enable pin
    logic                 oen_s2_r;   // settled enable pin
    logic                 clk_rise;   // rising edge of the clock pin

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r   <= '0;
            pin_s2_r   <= '0;
            clk_s1_r   <= 1'b0;
            clk_s2_r   <= 1'b0;
            clk_prev_r <= 1'b0;
            oen_s1_r   <= 1'b1;
            oen_s2_r   <= 1'b1;
        end else if (i_ce) begin
            pin_s1_r   <= i_cell_pin;
            pin_s2_r   <= pin_s1_r;
            clk_s1_r   <= i_pin_clk;
            clk_s2_r   <= clk_s1_r;
            clk_prev_r <= clk_s2_r;
            oen_s1_r   <= i_pin_oe_n;
            oen_s2_r   <= oen_s1_r;
        end
    end

    // edge taken from the settled copy, never from stage one
    assign clk_rise = clk_s2_r & ~clk_prev_r;

    // configuration registers
    // two global plus sixteen per-cell bits make the whole configuration
    omc_gcfg_t            cfg_r;     // global architecture bits
    omc_gcfg_t            cfg_nxt;
    logic [NUM_CELLS-1:0] pol_r;     // per-cell polarity
    logic [NUM_CELLS-1:0] pol_nxt;
    logic [NUM_CELLS-1:0] io_r;      // per-cell io select
    logic [NUM_CELLS-1:0] io_nxt;
    logic [31:0]          rdata_r;   // read data, valid one cycle
    logic [31:0]          rdata_nxt;
    logic                 preload_wr; // software preload of the registers
    logic [NUM_CELLS-1:0] q_vec;     // packed register state
    omc_mode_t            mode;

    // mode decode: registered wins over complex
    // so cfg code 3 also selects registered mode
    always_comb begin
        if (cfg_r.register_mode_select) begin
            mode = OMC_REGISTERED;
        end else if (cfg_r.global_arch_select) begin
            mode = OMC_COMPLEX;
        end else begin
            mode = OMC_SIMPLE;
        end
    end

    // register writes and reads; address decode by if chain
    always_comb begin
        cfg_nxt    = cfg_r;
        pol_nxt    = pol_r;
        io_nxt     = io_r;
        rdata_nxt  = `OMC_RST_RDATA;
        preload_wr = 1'b0;
        if (i_wr) begin
            // writes: only the defined bits are stored
            if (i_addr == `OMC_OFS_CFG) begin
                cfg_nxt.register_mode_select = i_wdata[`OMC_CFG_REG_SEL_BIT];
                cfg_nxt.global_arch_select   = i_wdata[`OMC_CFG_ARCH_SEL_BIT];
            end else if (i_addr == `OMC_OFS_POL) begin
                pol_nxt = i_wdata[NUM_CELLS-1:0];
            end else if (i_addr == `OMC_OFS_IO) begin
                io_nxt = i_wdata[NUM_CELLS-1:0];
            end else if (i_addr == `OMC_OFS_PRELOAD) begin
                preload_wr = 1'b1;
            end
        end
        if (i_rd) begin
            // reads: unmapped addresses and reserved bits read zero
            if (i_addr == `OMC_OFS_CFG) begin
                rdata_nxt[`OMC_CFG_REG_SEL_BIT]  = cfg_r.register_mode_select;
                rdata_nxt[`OMC_CFG_ARCH_SEL_BIT] = cfg_r.global_arch_select;
            end else if (i_addr == `OMC_OFS_POL) begin
                rdata_nxt[NUM_CELLS-1:0] = pol_r;
            end else if (i_addr == `OMC_OFS_IO) begin
                rdata_nxt[NUM_CELLS-1:0] = io_r;
            end else if (i_addr == `OMC_OFS_STATUS) begin
                rdata_nxt[`OMC_STAT_Q_LSB +: NUM_CELLS] = q_vec;
                rdata_nxt[`OMC_STAT_MODE_LSB +: 2]      = mode;
            end
        end
    end

    // configuration registers; frozen while the enable is low
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r   <= `OMC_RST_CFG;
            pol_r   <= `OMC_RST_POL;
            io_r    <= `OMC_RST_IO;
            rdata_r <= `OMC_RST_RDATA;
        end else if (i_ce) begin
            cfg_r   <= cfg_nxt;
            pol_r   <= pol_nxt;
            io_r    <= io_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // one macrocell per loop pass; cells 0 and 7 are the outer pair
    for (genvar g = 0; g < NUM_CELLS; g++) begin : g_cell
        // simple mode: array column g listens to the neighbouring pin
        // the outer cells carry the dedicated pins, so their index is clamped
        localparam int NB = (g == 0) ? 0 :
                            (g == NUM_CELLS - 1) ? g :
                            (g < NUM_CELLS / 2) ? g - 1 : g + 1;

        logic [PTERMS-1:0] pt;       // this cell's product terms
        logic              sum_all;  // or of all terms
        logic              sum_io;   // or of all but the enable term
        logic              oe_term;  // last term as output enable
        logic              q_r;      // macrocell register
        logic              q_nxt;
        logic              out_r;    // pin drive value
        logic              out_nxt;
        logic              oe_r;     // pin drive enable
        logic              oe_nxt;
        logic              fb_r;     // feedback column into the array
        logic              fb_nxt;

        assign pt = i_pterm[g*PTERMS +: PTERMS];

        // next values of the cell; the case is on the shared mode
        always_comb begin
            sum_all = |pt;
            sum_io  = |pt[PTERMS-2:0];
            oe_term = pt[PTERMS-1];
            // register holds unless a clock-pin edge or a preload comes
            q_nxt   = q_r;
            out_nxt = 1'b0;
            oe_nxt  = 1'b0;
            fb_nxt  = 1'b0;
            case (mode)
                OMC_REGISTERED: begin
                    if (!io_r[g]) begin
                        // registered cell: shared clock pin edge
                        if (clk_rise) begin
                            q_nxt = sum_all ^ pol_r[g];
                        end
                        out_nxt = q_nxt;
                        // enable pin only; low drives the pin
                        oe_nxt  = ~oen_s2_r;
                        fb_nxt  = q_nxt;
                    end else begin
                        // combinational io: seven terms, one for enable
                        out_nxt = sum_io ^ pol_r[g];
                        oe_nxt  = oe_term;
                        fb_nxt  = pin_s2_r[g];
                    end
                end
                OMC_COMPLEX: begin
                    out_nxt = sum_io ^ pol_r[g];
                    oe_nxt  = oe_term;
                    if (g == 0) begin
                        fb_nxt = oen_s2_r;
                    end else if (g == NUM_CELLS - 1) begin
                        fb_nxt = clk_s2_r;
                    end else begin
                        fb_nxt = io_r[g] & pin_s2_r[g];
                    end
                end
                default: begin
                    // simple mode; the inner pair is always an output
                    if (io_r[g] && g != INNER_LO && g != INNER_HI) begin
                        oe_nxt = 1'b0;
                    end else begin
                        out_nxt = sum_all ^ pol_r[g];
                        oe_nxt  = 1'b1;
                    end
                    // outer columns carry the two dedicated pins
                    if (g == 0) begin
                        fb_nxt = oen_s2_r;
                    end else if (g == NUM_CELLS - 1) begin
                        fb_nxt = clk_s2_r;
                    end else begin
                        fb_nxt = pin_s2_r[NB];
                    end
                end
            endcase
            // preload overrides a clock edge in the same cycle
            if (preload_wr) begin
                q_nxt = i_wdata[g];
            end
        end

        // cell state; register cleared at reset
        // pin levels that come and go while frozen are never seen
        always_ff @(posedge i_mclk or negedge rst_n) begin
            if (!rst_n) begin
                q_r   <= 1'b0;
                out_r <= 1'b0;
                oe_r  <= 1'b0;
                fb_r  <= 1'b0;
            end else if (i_ce) begin
                q_r   <= q_nxt;
                out_r <= out_nxt;
                oe_r  <= oe_nxt;
                fb_r  <= fb_nxt;
            end
        end

        assign q_vec[g]      = q_r;
        assign o_cell_out[g] = out_r;
        assign o_cell_oe[g]  = oe_r;
        assign o_array_fb[g] = fb_r;
    end

    // outputs
    // mode follows the cfg flops, so it shows the cycle after a write
    assign o_rdata = rdata_r;
    assign o_mode  = mode;

endmodule : omc_output_macrocell

// *** rtl/omc_defs.svh ***
// register offsets, reset values and field positions of the output macrocell block
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH

// byte addresses of the register words
`define OMC_OFS_CFG     8'h00
`define OMC_OFS_POL     8'h04
`define OMC_OFS_IO      8'h08
`define OMC_OFS_PRELOAD 8'h0C
`define OMC_OFS_STATUS  8'h10

// field positions inside the global configuration word
`define OMC_CFG_REG_SEL_BIT  0
`define OMC_CFG_ARCH_SEL_BIT 1

// field positions inside the status word
`define OMC_STAT_Q_LSB    0
`define OMC_STAT_MODE_LSB 8

// reset values
`define OMC_RST_CFG   2'h0
`define OMC_RST_POL   8'h00
`define OMC_RST_IO    8'h00
`define OMC_RST_Q     8'h00
`define OMC_RST_RDATA 32'h00000000

`endif

// *** rtl/omc_pkg.sv ***
// types shared by the output macrocell block
package omc_pkg;

    // global macrocell mode, one for all cells
    typedef enum logic [1:0] {
        OMC_SIMPLE,
        OMC_COMPLEX,
        OMC_REGISTERED
    } omc_mode_t;

    // the two global architecture bits
    typedef struct packed {
        logic global_arch_select;
        logic register_mode_select;
    } omc_gcfg_t;

endpackage : omc_pkg

// *** sim/omc_board.sv ***
// board model driving the dedicated pins and the macrocell pins
`timescale 1ns/1ps
module omc_board (
    // clock and bench commands
    input  wire logic       i_mclk,
    input  wire logic       i_pulse,
    input  wire logic       i_oe_n,
    input  wire logic [7:0] i_drv,
    // device side
    input  wire logic [7:0] i_cell_out,
    input  wire logic [7:0] i_cell_oe,
    output logic            o_pin_clk,
    output logic            o_pin_oe_n,
    output logic [7:0]      o_cell_pin
);
    logic [3:0] ph_r; // pulse phase: four high, four low
    initial ph_r = 4'h0;
    // clock pin idles low, each level held long enough to be seen
    always @(posedge i_mclk) begin
        if (ph_r != 4'h0) begin
            ph_r <= ph_r - 4'h1;
        end else if (i_pulse) begin
            ph_r <= 4'h8;
        end
    end
    assign o_pin_clk  = (ph_r > 4'h4);
    assign o_pin_oe_n = i_oe_n;
    // device wins where it drives, board elsewhere
    assign o_cell_pin = (i_cell_oe & i_cell_out) | (~i_cell_oe & i_drv);
endmodule : omc_board

// *** sim/omc_chk.sv ***
// assertion checker for the output macrocell block
`timescale 1ns/1ps
module omc_chk
    import omc_pkg::*;
#(
    parameter int NUM_CELLS = 8,
    parameter int PTERMS    = 8
) (
    // clock, reset, enable
    input wire logic                 i_mclk,
    input wire logic                 i_reset_n,
    input wire logic                 i_ce,
    // register port
    input wire logic [7:0]           i_addr,
    input wire logic [31:0]          i_wdata,
    input wire logic                 i_wr,
    input wire logic                 i_rd,
    input wire logic [31:0]          o_rdata,
    // pins and array side
    input wire logic [NUM_CELLS-1:0] o_array_fb,
    input wire logic                 i_pin_clk,
    input wire logic                 i_pin_oe_n,
    input wire logic [NUM_CELLS-1:0] o_cell_out,
    input wire logic [NUM_CELLS-1:0] o_cell_oe,
    input wire omc_mode_t            o_mode
);
    logic [2:0]           rel_r;  // edges since reset release
    logic [2:0]           rel_nxt;
    logic [NUM_CELLS-1:0] io_r;   // shadow of the io bits
    logic [NUM_CELLS-1:0] io_nxt;
    logic                 ok;     // reset pipeline drained
    // next helper state
    always_comb begin
        rel_nxt = (rel_r == 3'h4) ? rel_r : rel_r + 3'h1;
        io_nxt  = io_r;
        if (i_ce && i_wr && i_addr == 8'h08) begin
            io_nxt = i_wdata[NUM_CELLS-1:0];
        end
    end
    // register helper state
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rel_r <= 3'h0;
            io_r  <= '0;
        end else begin
            rel_r <= rel_nxt;
            io_r  <= io_nxt;
        end
    end
    assign ok = (rel_r == 3'h4);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    // steady spans in one mode, or anywhere outside registered mode
    sequence s_run(m);
        o_mode == m && i_ce && ok;
    endsequence
    sequence s_reg_oe(v);
        o_mode == OMC_REGISTERED && i_pin_oe_n == v && i_ce && ok && $stable(io_r);
    endsequence
    sequence s_pins;
        o_mode != OMC_REGISTERED && i_ce && ok && $stable(i_pin_oe_n) && $stable(i_pin_clk);
    endsequence
    sequence s_quiet;
        o_mode == OMC_REGISTERED && !i_pin_clk && !i_wr && ok && $stable(io_r);
    endsequence
    property p_rd_idle;
        i_ce && !i_rd |=> o_rdata == 32'h0;
    endproperty
    property p_mode_reg;
        i_ce && i_wr && i_addr == 8'h00 && i_wdata[0] |=> o_mode == OMC_REGISTERED;
    endproperty
    property p_mode_cplx;
        i_ce && i_wr && i_addr == 8'h00 && i_wdata[1:0] == 2'h2 |=> o_mode == OMC_COMPLEX;
    endproperty
    property p_mode_hold;
        !(i_ce && i_wr && i_addr == 8'h00) |=> $stable(o_mode);
    endproperty
    property p_status;
        i_ce && i_rd && i_addr == 8'h10 |=> o_rdata[9:8] == $past(o_mode);
    endproperty
    property p_simple_inner;
        s_run(OMC_SIMPLE) [*4] |-> o_cell_oe[4:3] == 2'h3;
    endproperty
    property p_reg_off;
        s_reg_oe(1'b1) [*4] |-> (o_cell_oe & ~io_r) == '0;
    endproperty
    property p_reg_on;
        s_reg_oe(1'b0) [*4] |-> (o_cell_oe | io_r) == '1;
    endproperty
    property p_pin_fb;
        s_pins [*4] |-> o_array_fb[0] == i_pin_oe_n && o_array_fb[NUM_CELLS-1] == i_pin_clk;
    endproperty
    property p_reg_hold;
        s_quiet [*6] |-> $stable(o_array_fb & ~io_r);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_mode_reg: assert property (p_mode_reg) else $error("no registered mode");
    a_mode_cplx: assert property (p_mode_cplx) else $error("no complex mode");
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
    a_status: assert property (p_status) else $error("status mode wrong");
    a_simple_inner: assert property (p_simple_inner) else $error("inner off");
    a_reg_off: assert property (p_reg_off) else $error("driver on");
    a_reg_on: assert property (p_reg_on) else $error("driver off");
    a_pin_fb: assert property (p_pin_fb) else $error("pin column wrong");
    a_reg_hold: assert property (p_reg_hold) else $error("register moved");
endmodule : omc_chk

// *** sim/testbench.sv ***
// self-checking bench for the output macrocell block
`timescale 1ns/1ps
module testbench;
    import omc_pkg::*;
    localparam logic [1:0] MDX [4] = '{2'h0, 2'h2, 2'h1, 2'h2}; // mode per cfg code
    logic        mclk, reset_n, ce, wr, rd, pulse, oe_n, pin_clk, pin_oe_n;
    logic [7:0]  addr, drv, fb, c_out, c_oe, c_pin;
    logic [31:0] wdata, rdata, rv;
    logic [63:0] pterm;
    omc_mode_t   mode;
    int          bad_count, compares;
    omc_output_macrocell u_dut (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pterm(pterm), .o_array_fb(fb),
        .i_pin_clk(pin_clk), .i_pin_oe_n(pin_oe_n), .i_cell_pin(c_pin),
        .o_cell_out(c_out), .o_cell_oe(c_oe), .o_mode(mode));
    omc_board u_board (
        .i_mclk(mclk), .i_pulse(pulse), .i_oe_n(oe_n), .i_drv(drv), .i_cell_out(c_out),
        .i_cell_oe(c_oe), .o_pin_clk(pin_clk), .o_pin_oe_n(pin_oe_n), .o_cell_pin(c_pin));
    // clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // waits whole cycles; values read at the edge are the settled ones
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        {rd, addr} <= {1'b1, a};
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        d = rdata;
    endtask : rd_reg
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    // hang guard, far beyond the hundred-odd cycles needed
    initial begin
        wt(4000);
        bad_count++;
        close_out;
    end
    initial begin
        {reset_n, ce, wr, rd, pulse, oe_n} = 6'h10;
        {addr, wdata, pterm, drv} = {8'h00, 32'h0, 64'h0, 8'hF0};
        wt(20);
        reset_n <= 1'b1;
        wt(4);
        chk("mode", 32'h0, {30'h0, mode});
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h00, 32'(i));
            rd_reg(8'h10, rv);
            chk("status", {22'h0, MDX[i], 8'h00}, rv);
        end
        rd_reg(8'h14, rv);
        chk("unmapped", 32'h0, rv);
        // write lost while the clock enable is low
        ce <= 1'b0;
        wr_reg(8'h00, 32'h2);
        ce <= 1'b1;
        wt(1);
        chk("mode", 32'h2, {30'h0, mode});
        // registered: preload, then capture of all eight terms on a pin clock
        wr_reg(8'h04, 32'h0F);
        wr_reg(8'h08, 32'h0);
        wr_reg(8'h0C, 32'hA5);
        wt(4);
        chk("out", 32'hA5, {24'h0, c_out});
        chk("oe", 32'hFF, {24'h0, c_oe});
        pterm <= 64'h0080008000800080;
        pulse <= 1'b1;
        wt(1);
        pulse <= 1'b0;
        wt(12);
        chk("out", 32'h5A, {24'h0, c_out});
        rd_reg(8'h10, rv);
        chk("status", 32'h25A, rv);
        oe_n <= 1'b1;
        wt(6);
        chk("oe", 32'h0, {24'h0, c_oe});
        chk("feedback", 32'h5A, {24'h0, fb});
        // cells 0 and 7 to io: seven terms, eighth drives their enable
        wr_reg(8'h08, 32'h81);
        wt(6);
        chk("out", 32'h5B, {24'h0, c_out});
        chk("oe", 32'h01, {24'h0, c_oe});
        chk("feedback", 32'hDB, {24'h0, fb});
        // complex: seven logic terms, eighth drives the enable
        wr_reg(8'h00, 32'h2);
        wr_reg(8'h04, 32'h0);
        // outer io bits set too: outer cells must still ignore them
        wr_reg(8'h08, 32'hFF);
        pterm <= 64'h0080008001810181;
        wt(8);
        chk("out", 32'h0F, {24'h0, c_out});
        chk("oe", 32'h55, {24'h0, c_oe});
        chk("feedback", 32'h25, {24'h0, fb});
        // simple: input cells, inner cells forced out, neighbour feedback
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h04, 32'h80);
        wr_reg(8'h08, 32'h19);
        wt(8);
        chk("out", 32'hDE, {24'h0, c_out & 8'hFE});
        chk("oe", 32'hFE, {24'h0, c_oe});
        chk("feedback", 32'h6D, {24'h0, fb});
        close_out;
    end
endmodule : testbench
bind omc_output_macrocell omc_chk #(.NUM_CELLS(NUM_CELLS), .PTERMS(PTERMS)) u_chk (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_array_fb(o_array_fb),
    .i_pin_clk(i_pin_clk), .i_pin_oe_n(i_pin_oe_n), .o_cell_out(o_cell_out),
    .o_cell_oe(o_cell_oe), .o_mode(o_mode));
